// *** far_node_model.sv ***
/*
  far-side serial node: paces bit times and drives the receive pin away
  from its idle level for a chosen number of bit times.
  assumes it shares ref_clk_i with the block; idle level set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module far_node_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       send_i,
  input  wire logic       idle_hi_i,
  input  wire logic [3:0] low_bits_i,
  output logic            rx_pin_o,
  output logic            bit_tick_o,
  output logic            busy_o
);
  logic [1:0] div_ff;
  logic [3:0] want_ff;
  logic [3:0] lows_ff;
  logic       act_ff;
  // break level is the inverse of idle, so a flipped receiver still sees a break
  assign rx_pin_o = idle_hi_i ^ act_ff;
  assign busy_o   = (want_ff != 4'h0) || act_ff;
  // run starts right after a tick, so exactly want_ff ticks see it active
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      div_ff <= 2'h0;
      want_ff <= 4'h0;
      lows_ff <= 4'h0;
      act_ff <= 1'b0;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      div_ff <= div_ff + 2'h1;
      bit_tick_o <= (div_ff == 2'h3);
      if (send_i)
        want_ff <= low_bits_i;
      if (bit_tick_o && act_ff)
      begin
        lows_ff <= lows_ff + 4'h1;
        if (lows_ff + 4'h1 == want_ff)
        begin
          act_ff <= 1'b0;
          want_ff <= 4'h0;
        end
      end
      else if (bit_tick_o && want_ff != 4'h0)
      begin
        act_ff <= 1'b1;
        lows_ff <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** serial_port_s2c3_pkg.sv ***
/*
  constants for the serial port second status / third control block:
  register offsets, field positions, reset values and break lengths.
  assumes a 32-bit apb bus with one register per aligned word.
*/
`default_nettype none
package serial_port_s2c3_pkg;
  localparam logic [7:0] OFS_LINE_STATUS_EXTRA  = 8'h00;
  localparam logic [7:0] OFS_LINE_CONTROL_EXTRA = 8'h04;
  localparam logic [7:0] OFS_DATA_BUFFER        = 8'h08;
  localparam logic [7:0] OFS_RX_STATUS          = 8'h0c;
  localparam logic [7:0] OFS_FRAME_CONTROL      = 8'h10;

  // line_status_extra fields
  localparam int BIT_BREAK_DET_FLAG = 7;
  localparam int BIT_RX_EDGE_FLAG   = 6;
  localparam int BIT_RX_FLIP        = 4;
  localparam int BIT_WAKE_IDLE      = 3;
  localparam int BIT_LONG_BREAK     = 2;
  localparam int BIT_BREAK_DET_EN   = 1;
  localparam int BIT_RX_ACTIVE      = 0;

  // line_control_extra fields
  localparam int BIT_RX_NINTH   = 7;
  localparam int BIT_TX_NINTH   = 6;
  localparam int BIT_SW_DIR     = 5;
  localparam int BIT_TX_FLIP    = 4;
  localparam int BIT_OR_IE      = 3;
  localparam int BIT_NE_IE      = 2;
  localparam int BIT_FE_IE      = 1;
  localparam int BIT_PE_IE      = 0;

  // rx_status fields
  localparam int BIT_RX_FULL    = 5;
  localparam int BIT_IDLE       = 4;
  localparam int BIT_OVERRUN    = 3;
  localparam int BIT_NOISE      = 2;
  localparam int BIT_FRAME_ERR  = 1;
  localparam int BIT_PARITY_ERR = 0;

  // frame_control fields
  localparam int BIT_WIDE_CHAR  = 0;
  localparam int BIT_LOOP       = 1;
  localparam int BIT_RX_SOURCE  = 2;
  localparam int BIT_RX_STANDBY = 3;

  // lengths in bit times, 8-bit frames; 9-bit frames add one, except to LOW_CNT_MAX
  localparam logic [3:0] BREAK_TX_SHORT = 4'ha;
  localparam logic [3:0] BREAK_TX_LONG  = 4'hd;
  localparam logic [3:0] BREAK_DET_STD  = 4'ha;
  localparam logic [3:0] BREAK_DET_LIN  = 4'hb;
  localparam logic [3:0] LOW_CNT_MAX    = 4'hf;

  localparam logic [7:0] RESET_BYTE     = 8'h00;
endpackage
`default_nettype wire

// *** serial_port_status2_control3.sv ***
/*
  second status and third control registers of an asynchronous serial port,
  with break detect/send, polarity flips, ninth bits, single-wire direction
  and error interrupt enables, reached over apb.
  assumes the baud generator and shifters sit outside, all on ref_clk_i,
  and that bit_tick_i pulses once per bit time.
*/
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - break seen while enabled sets sticky flag
// - active receive edge sets flag, write clears
// - receive flip inverts the whole receive stream
// - standby idle sets idle only if chosen
// - sent break 10/13 bits, plus nine-bit
// - framing check ignores break length select
// - break threshold 10/11 bits, plus nine-bit
// - break detect enable blocks frame/full flags
// - active flag on start, cleared on idle
// - ninth received bit shown in control bit7
// - ninth transmit bit loaded with data write
// - single-wire mode direction follows control bit
// - transmit flip inverts the whole transmit stream
// - overrun and enable raise interrupt request
// - noise and enable raise interrupt request
// - framing error and enable raise request
// - parity error and enable raise request
// - overrun when buffer full, new char dropped
// - zero stop bit sets framing error, full
module serial_port_status2_control3 (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        bit_tick_i,
  input  wire logic        rx_pin_i,
  input  wire logic        tx_pin_i,
  input  wire logic        tx_line_i,
  input  wire logic        tx_break_req_i,
  input  wire logic        rx_start_i,
  input  wire logic        rx_idle_i,
  input  wire logic        rx_char_done_i,
  input  wire logic [8:0]  rx_char_i,
  input  wire logic        rx_stop_bit_i,
  input  wire logic        rx_noise_i,
  input  wire logic        rx_parity_err_i,
  output logic             rx_line_o,
  output logic             tx_pin_o,
  output logic             tx_pin_oe_o,
  output logic             tx_load_o,
  output logic [8:0]       tx_word_o,
  output logic             tx_break_busy_o,
  output logic             wide_char_o,
  output logic             irq_req_o
);
  typedef struct packed {
    logic       brk_flag;
    logic       edge_flag;
    logic       rx_flip;
    logic       wake_idle;
    logic       long_brk;
    logic       brk_en;
    logic       rx_active;
    logic       tx_ninth;
    logic       sw_dir;
    logic       tx_flip;
    logic [3:0] err_ie;
    logic       rx_ninth;
    logic [7:0] rx_data;
    logic       rx_full;
    logic       idle;
    logic       overrun;
    logic       noise;
    logic       frame_err;
    logic       parity_err;
    logic       armed;
    logic       wide;
    logic       loop;
    logic       rx_source_sel;
    logic       standby;
    logic       prev_pin;
    logic [3:0] low_cnt;
    logic       brk_seen;
    logic [3:0] tx_cnt;
    logic [8:0] tx_word;
    logic       tx_load;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic       rx_raw;
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  logic [3:0] brk_thr;

  function automatic logic [3:0] break_len(input logic sel, input logic wide);
    break_len = (sel ? serial_port_s2c3_pkg::BREAK_TX_LONG : serial_port_s2c3_pkg::BREAK_TX_SHORT)
                + {3'h0, wide};
  endfunction

  function automatic logic [3:0] detect_len(input logic en, input logic wide);
    detect_len = (en ? serial_port_s2c3_pkg::BREAK_DET_LIN : serial_port_s2c3_pkg::BREAK_DET_STD)
                 + {3'h0, wide};
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // zero-wait slave; side effects only in the access phase
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_en     = psel_i & penable_i & ~pwrite_i;
  assign mapped    = hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_STATUS_EXTRA)
                   | hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_CONTROL_EXTRA)
                   | hit(paddr_i, serial_port_s2c3_pkg::OFS_DATA_BUFFER)
                   | hit(paddr_i, serial_port_s2c3_pkg::OFS_RX_STATUS)
                   | hit(paddr_i, serial_port_s2c3_pkg::OFS_FRAME_CONTROL);
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // loop mode feeds the receiver from the transmit side
  assign rx_raw    = st_ff.loop ? (st_ff.rx_source_sel ? tx_pin_i : tx_pin_o) : rx_pin_i;
  assign rx_line_o = rx_raw ^ st_ff.rx_flip;
  assign tx_pin_o  = ((st_ff.tx_cnt != 4'h0) ? 1'b0 : tx_line_i) ^ st_ff.tx_flip;
  // outside single-wire mode the pin always drives
  assign tx_pin_oe_o = ~(st_ff.loop & st_ff.rx_source_sel) | st_ff.sw_dir;
  assign tx_load_o       = st_ff.tx_load;
  assign tx_word_o       = st_ff.tx_word;
  assign tx_break_busy_o = (st_ff.tx_cnt != 4'h0);
  assign wide_char_o     = st_ff.wide;
  assign brk_thr         = detect_len(st_ff.brk_en, st_ff.wide);
  assign irq_req_o = (st_ff.overrun & st_ff.err_ie[serial_port_s2c3_pkg::BIT_OR_IE])
                   | (st_ff.noise & st_ff.err_ie[serial_port_s2c3_pkg::BIT_NE_IE])
                   | (st_ff.frame_err & st_ff.err_ie[serial_port_s2c3_pkg::BIT_FE_IE])
                   | (st_ff.parity_err & st_ff.err_ie[serial_port_s2c3_pkg::BIT_PE_IE]);

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_STATUS_EXTRA))
    begin
      // bit5 left at zero
      prdata_o[7:0] = {st_ff.brk_flag, st_ff.edge_flag, 1'b0, st_ff.rx_flip,
                       st_ff.wake_idle, st_ff.long_brk, st_ff.brk_en, st_ff.rx_active};
    end
    else if (hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_CONTROL_EXTRA))
    begin
      prdata_o[7:0] = {st_ff.rx_ninth, st_ff.tx_ninth, st_ff.sw_dir, st_ff.tx_flip, st_ff.err_ie};
    end
    else if (hit(paddr_i, serial_port_s2c3_pkg::OFS_DATA_BUFFER))
    begin
      prdata_o[7:0] = st_ff.rx_data;
    end
    else if (hit(paddr_i, serial_port_s2c3_pkg::OFS_RX_STATUS))
    begin
      prdata_o[5:0] = {st_ff.rx_full, st_ff.idle, st_ff.overrun, st_ff.noise, st_ff.frame_err, st_ff.parity_err};
    end
    else if (hit(paddr_i, serial_port_s2c3_pkg::OFS_FRAME_CONTROL))
    begin
      prdata_o[3:0] = {st_ff.standby, st_ff.rx_source_sel, st_ff.loop, st_ff.wide};
    end
  end

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.tx_load = 1'b0;
    nxt_st.prev_pin = rx_pin_i;

    // software writes first, so hardware sets below win
    if (wr_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_STATUS_EXTRA))
    begin
      if (pwdata_i[serial_port_s2c3_pkg::BIT_BREAK_DET_FLAG])
        nxt_st.brk_flag = 1'b0;
      if (pwdata_i[serial_port_s2c3_pkg::BIT_RX_EDGE_FLAG])
        nxt_st.edge_flag = 1'b0;
      nxt_st.rx_flip   = pwdata_i[serial_port_s2c3_pkg::BIT_RX_FLIP];
      nxt_st.wake_idle = pwdata_i[serial_port_s2c3_pkg::BIT_WAKE_IDLE];
      nxt_st.long_brk  = pwdata_i[serial_port_s2c3_pkg::BIT_LONG_BREAK];
      nxt_st.brk_en    = pwdata_i[serial_port_s2c3_pkg::BIT_BREAK_DET_EN];
    end
    if (wr_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_LINE_CONTROL_EXTRA))
    begin
      nxt_st.tx_ninth = pwdata_i[serial_port_s2c3_pkg::BIT_TX_NINTH];
      nxt_st.sw_dir   = pwdata_i[serial_port_s2c3_pkg::BIT_SW_DIR];
      nxt_st.tx_flip  = pwdata_i[serial_port_s2c3_pkg::BIT_TX_FLIP];
      nxt_st.err_ie   = pwdata_i[3:0];
    end
    if (wr_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_FRAME_CONTROL))
    begin
      nxt_st.wide    = pwdata_i[serial_port_s2c3_pkg::BIT_WIDE_CHAR];
      nxt_st.loop    = pwdata_i[serial_port_s2c3_pkg::BIT_LOOP];
      nxt_st.rx_source_sel    = pwdata_i[serial_port_s2c3_pkg::BIT_RX_SOURCE];
      nxt_st.standby = pwdata_i[serial_port_s2c3_pkg::BIT_RX_STANDBY];
    end
    // ninth bit as it stands now goes with the byte
    if (wr_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_DATA_BUFFER))
    begin
      nxt_st.tx_word = {st_ff.tx_ninth & st_ff.wide, pwdata_i[7:0]};
      nxt_st.tx_load = 1'b1;
    end

    // status read with a flag up, then data read, clears the receive flags
    if (rd_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_RX_STATUS))
      nxt_st.armed = st_ff.rx_full | st_ff.idle | st_ff.overrun | st_ff.noise
                   | st_ff.frame_err | st_ff.parity_err;
    if (rd_en && hit(paddr_i, serial_port_s2c3_pkg::OFS_DATA_BUFFER) && st_ff.armed)
    begin
      nxt_st.armed      = 1'b0;
      nxt_st.rx_full    = 1'b0;
      nxt_st.idle       = 1'b0;
      nxt_st.overrun    = 1'b0;
      nxt_st.noise      = 1'b0;
      nxt_st.frame_err  = 1'b0;
      nxt_st.parity_err = 1'b0;
    end

    // edge of the pin in the polarity the receiver treats as start
    if ((st_ff.prev_pin != rx_pin_i) && (rx_pin_i == st_ff.rx_flip))
      nxt_st.edge_flag = 1'b1;

    // active flag: set beats clear when both arrive together
    if (rx_idle_i)
      nxt_st.rx_active = 1'b0;
    if (rx_start_i)
      nxt_st.rx_active = 1'b1;

    if (rx_idle_i && (!st_ff.standby || st_ff.wake_idle))
      nxt_st.idle = 1'b1;
    // the waking idle takes the receiver out of standby
    if (rx_idle_i && st_ff.standby)
      nxt_st.standby = 1'b0;

    // count low bit times; one report per low run
    if (bit_tick_i)
    begin
      if (rx_line_o)
      begin
        nxt_st.low_cnt  = 4'h0;
        nxt_st.brk_seen = 1'b0;
      end
      else
      begin
        if (st_ff.low_cnt != serial_port_s2c3_pkg::LOW_CNT_MAX)
          nxt_st.low_cnt = st_ff.low_cnt + 4'h1;
        if (!st_ff.brk_seen && (st_ff.low_cnt + 4'h1 == brk_thr))
        begin
          nxt_st.brk_seen = 1'b1;
          if (st_ff.brk_en)
            nxt_st.brk_flag = 1'b1;
        end
      end
    end

    // framing check uses the stop bit only, long_brk plays no part
    if (rx_char_done_i && !st_ff.brk_en)
    begin
      if (st_ff.rx_full)
        nxt_st.overrun = 1'b1;
      else
      begin
        nxt_st.rx_full    = 1'b1;
        nxt_st.rx_data    = rx_char_i[7:0];
        nxt_st.rx_ninth   = rx_char_i[8] & st_ff.wide;
        nxt_st.frame_err  = ~rx_stop_bit_i;
        nxt_st.noise      = rx_noise_i;
        nxt_st.parity_err = rx_parity_err_i;
        nxt_st.idle       = 1'b0;
      end
    end

    // break sender counts bit times; requests while busy are dropped
    if (st_ff.tx_cnt == 4'h0)
    begin
      if (tx_break_req_i)
        nxt_st.tx_cnt = break_len(st_ff.long_brk, st_ff.wide);
    end
    else if (bit_tick_i)
      nxt_st.tx_cnt = st_ff.tx_cnt - 4'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_ff          <= '0;
      st_ff.prev_pin <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  property p_brk_flag;
    @(posedge ref_clk_i) disable iff (reset_i)
      bit_tick_i && st_ff.brk_en && !rx_line_o && !st_ff.brk_seen && (st_ff.low_cnt + 4'h1 == brk_thr)
      |=> st_ff.brk_flag;
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break not flagged at threshold");

  property p_brk_off;
    @(posedge ref_clk_i) disable iff (reset_i)
      $rose(st_ff.brk_flag) |-> $past(st_ff.brk_en) && ($past(st_ff.low_cnt) + 4'h1 == $past(brk_thr));
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("break flagged off threshold");

  property p_edge;
    @(posedge ref_clk_i) disable iff (reset_i)
      (st_ff.prev_pin != rx_pin_i) && (rx_pin_i == st_ff.rx_flip) |=> st_ff.edge_flag;
  endproperty
  a_edge: assert property (p_edge) else $error("active edge missed");

  property p_rx_flip;
    @(posedge ref_clk_i) disable iff (reset_i)
      !st_ff.loop |-> (rx_line_o == (rx_pin_i ^ st_ff.rx_flip));
  endproperty
  a_rx_flip: assert property (p_rx_flip) else $error("receive polarity wrong");

  property p_wake_idle;
    @(posedge ref_clk_i) disable iff (reset_i)
      rx_idle_i && st_ff.standby && !st_ff.wake_idle && !st_ff.idle && !rx_char_done_i |=> !st_ff.idle;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle set in standby");

  sequence s_brk_start;
    (st_ff.tx_cnt == 4'h0) && tx_break_req_i;
  endsequence
  property p_brk_len;
    @(posedge ref_clk_i) disable iff (reset_i)
      s_brk_start |=> (st_ff.tx_cnt == break_len($past(st_ff.long_brk), $past(st_ff.wide)))
                      && (tx_pin_o == st_ff.tx_flip);
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length or level wrong");

  property p_block;
    @(posedge ref_clk_i) disable iff (reset_i)
      $rose(st_ff.rx_full) || $rose(st_ff.frame_err) |-> !$past(st_ff.brk_en);
  endproperty
  a_block: assert property (p_block) else $error("flag set with break detect on");

  property p_active;
    @(posedge ref_clk_i) disable iff (reset_i)
      rx_start_i |=> st_ff.rx_active;
  endproperty
  a_active: assert property (p_active) else $error("active flag not set");

  property p_dir;
    @(posedge ref_clk_i) disable iff (reset_i)
      st_ff.loop && st_ff.rx_source_sel |-> (tx_pin_oe_o == st_ff.sw_dir);
  endproperty
  a_dir: assert property (p_dir) else $error("single-wire direction wrong");

  property p_irq;
    @(posedge ref_clk_i) disable iff (reset_i)
      irq_req_o == |({st_ff.overrun, st_ff.noise, st_ff.frame_err, st_ff.parity_err} & st_ff.err_ie);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  property p_overrun;
    @(posedge ref_clk_i) disable iff (reset_i)
      rx_char_done_i && !st_ff.brk_en && st_ff.rx_full |=> st_ff.overrun && $stable(st_ff.rx_data);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_frame;
    @(posedge ref_clk_i) disable iff (reset_i)
      rx_char_done_i && !st_ff.brk_en && !st_ff.rx_full && !rx_stop_bit_i |=> st_ff.frame_err && st_ff.rx_full;
  endproperty
  a_frame: assert property (p_frame) else $error("framing error missed");
endmodule
`default_nettype wire

// *** serial_port_status2_control3_tb_top.sv ***
/*
  self-checking bench: apb master, receive event pulses, far node on rx pin.
  assumes zero-wait apb and a bit tick every four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_port_status2_control3_tb_top;
  localparam logic [7:0] ST = serial_port_s2c3_pkg::OFS_LINE_STATUS_EXTRA;
  localparam logic [7:0] CT = serial_port_s2c3_pkg::OFS_LINE_CONTROL_EXTRA;
  localparam logic [7:0] DB = serial_port_s2c3_pkg::OFS_DATA_BUFFER;
  localparam logic [7:0] RS = serial_port_s2c3_pkg::OFS_RX_STATUS;
  localparam logic [7:0] FC = serial_port_s2c3_pkg::OFS_FRAME_CONTROL;
  localparam logic [7:0] ofs [5] = '{ST, CT, DB, RS, FC};
  // {status cfg, wide, low bits, expected status}
  localparam logic [23:0] brk_tab [7] = '{24'h020a42, 24'h020bc2, 24'h021b42,
    24'h021cc2, 24'h000c40, 24'h100a50, 24'h120bd2};
  logic        clk, rst, psel, pen, pwr, tx_pin, tx_line, send, rerr, idle_hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdat;
  logic [8:0]  rch, lword;
  logic [3:0]  ev, nlow;
  logic [2:0]  flg;
  wire  [31:0] prdata;
  wire  [8:0]  tword;
  wire         pready, pslverr, rx_pin, tick, busy, rx_line, txo, oe, ld, bbusy, wide, irq;
  int          failures, n_checks, nbrk, nld;

  serial_port_status2_control3 serial_port_status2_control3_i (
    .ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bit_tick_i(tick), .rx_pin_i(rx_pin), .tx_pin_i(tx_pin),
    .tx_line_i(tx_line), .tx_break_req_i(ev[2]), .rx_start_i(ev[1]), .rx_idle_i(ev[0]),
    .rx_char_done_i(ev[3]), .rx_char_i(rch), .rx_stop_bit_i(flg[2]), .rx_noise_i(flg[1]),
    .rx_parity_err_i(flg[0]), .rx_line_o(rx_line), .tx_pin_o(txo), .tx_pin_oe_o(oe),
    .tx_load_o(ld), .tx_word_o(tword), .tx_break_busy_o(bbusy), .wide_char_o(wide),
    .irq_req_o(irq));
  far_node_model far_node_model_i (.ref_clk_i(clk), .reset_i(rst), .send_i(send), .idle_hi_i(idle_hi),
    .low_bits_i(nlow), .rx_pin_o(rx_pin), .bit_tick_o(tick), .busy_o(busy));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (bbusy === 1'b1 && tick === 1'b1)
      nbrk++;
    if (ld === 1'b1)
    begin
      nld++;
      lword = tword;
    end
  end

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang(input int k, input int lim);
    if (k >= lim)
    begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    hang(k, 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic pulse(input logic [3:0] e, input logic [8:0] c, input logic [2:0] f);
    @(posedge clk);
    ev <= e;
    rch <= c;
    flg <= f;
    @(posedge clk);
    ev <= 4'h0;
    @(negedge clk);
  endtask

  task automatic run_low(input logic [3:0] n);
    int k;
    @(posedge clk);
    send <= 1'b1;
    nlow <= n;
    @(posedge clk);
    send <= 1'b0;
    // busy only shows once the request has been registered
    @(negedge clk);
    for (k = 0; k < 300 && busy; k++)
      @(negedge clk);
    hang(k, 300);
    // covers a full threshold of ticks after the pin returns to its idle level
    repeat (60) @(posedge clk);
  endtask

  initial
  begin
    logic [8:0] c1;
    int i, k;
    {psel, pen, pwr, tx_line, send, rerr, paddr, pwdata, rch, ev, nlow} = '0;
    tx_pin = 1'b1;
    idle_hi = 1'b1;
    flg = 3'h4;
    rst = 1'b1;
    failures = 0;
    n_checks = 0;
    i = $urandom(32'hea374282);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[j])
      rdc(ofs[j], 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, ST, 32'h20);
    rdc(ST, 32'h0);
    $display("test registers done");
    apb(1'b1, FC, 32'h1);
    apb(1'b1, ST, 32'h4);
    c1 = 9'($urandom);
    pulse(4'h8, c1, 3'h3);
    pulse(4'h8, ~c1, 3'h4);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, CT, 32'h1 << i);
      chk(32'(irq), 32'h1);
      apb(1'b1, CT, 32'h0);
      chk(32'(irq), 32'h0);
    end
    rdc(RS, 32'h2f);
    rdc(CT, {24'h0, c1[8], 7'h0});
    rdc(DB, {24'h0, c1[7:0]});
    rdc(RS, 32'h0);
    apb(1'b1, CT, 32'hf);
    chk(32'(irq), 32'h0);
    apb(1'b1, ST, 32'h2);
    pulse(4'h8, 9'($urandom), 3'h0);
    rdc(RS, 32'h0);
    $display("test receive flags done");
    foreach (brk_tab[j])
    begin
      apb(1'b1, FC, 32'(brk_tab[j][15:12]));
      apb(1'b1, ST, {24'h0, brk_tab[j][23:16] | 8'hc0});
      @(posedge clk);
      idle_hi <= ~brk_tab[j][20];
      run_low(brk_tab[j][11:8]);
      rdc(ST, 32'(brk_tab[j][7:0]));
    end
    chk(32'(rx_line), {31'h0, ~rx_pin});
    @(posedge clk);
    idle_hi <= 1'b1;
    $display("test break detect done");
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, FC, 32'h8);
      apb(1'b1, ST, 32'hc0 | (32'(i) << 3));
      pulse(4'h1, 9'h0, 3'h4);
      rdc(RS, 32'(i) << 4);
    end
    apb(1'b0, DB, 32'h0);
    pulse(4'h2, 9'h0, 3'h4);
    rdc(ST, 32'h9);
    pulse(4'h1, 9'h0, 3'h4);
    rdc(ST, 32'h8);
    $display("test standby and active done");
    apb(1'b1, CT, 32'h10);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, FC, 32'(i & 1));
      apb(1'b1, ST, 32'(i & 2) << 1);
      nbrk = 0;
      pulse(4'h4, 9'h0, 3'h4);
      chk(32'(txo), 32'h1);
      for (k = 0; k < 300 && bbusy; k++)
        @(negedge clk);
      hang(k, 300);
      chk(32'(nbrk), 32'(10 + 3 * (i >> 1) + (i & 1)));
    end
    @(posedge clk);
    tx_line <= 1'($urandom);
    @(negedge clk);
    chk(32'(txo), {31'h0, ~tx_line});
    $display("test break send done");
    apb(1'b1, FC, 32'h6);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, CT, 32'(i) << 5);
      chk(32'(oe), 32'(i));
    end
    apb(1'b1, FC, 32'h2);
    chk(32'(rx_line), {31'h0, tx_line});
    chk(32'(oe), 32'h1);
    apb(1'b1, FC, 32'h1);
    chk(32'(wide), 32'h1);
    apb(1'b1, CT, 32'h40);
    nld = 0;
    for (i = 0; i < 3; i++)
    begin
      c1 = 9'($urandom);
      if (i == 2)
        apb(1'b1, FC, 32'h0);
      apb(1'b1, DB, {24'h0, c1[7:0]});
      repeat (2) @(negedge clk);
      chk(32'(lword), {23'h0, i < 2, c1[7:0]});
    end
    chk(32'(nld), 32'h3);
    $display("test transmit side done");
    give_verdict();
  end
endmodule
`default_nettype wire
